// ### alert_pkg.sv
// package of constants, register map and field layout for the valve alert monitor
//==========================================================================
// Function
// - drive current alert when current error exceeds limit longer than alert time
// - zero-power closed: drive<10% with travel>3%, or drive>90% with travel<97%
// - zero-power open: drive<10% with travel<97%, or drive>90% with travel>3%
// - drive signal alert reports only; never changes mode or output
// - shutdown-configured active alert forces transducer out of service while present
// - out of service drives output pressures and position to zero power
// - processor impaired from four enabled memory and processor failure conditions
// - output block timeout when setpoint block unexecuted longer than timeout
package alert_pkg;
  // percentages in tenths of a percent, 0..1000
  localparam int          PCT_W        = 10;
  localparam logic [9:0]  DRIVE_LO     = 10'h064;
  localparam logic [9:0]  DRIVE_HI     = 10'h384;
  localparam logic [9:0]  TRAVEL_LO    = 10'h01E;
  localparam logic [9:0]  TRAVEL_HI    = 10'h3CA;
  // one millisecond tick at 100 MHz
  localparam int          CLK_MHZ      = 100;
  localparam int          TICK_US      = 1000;
  localparam int          TICK_CYC     = CLK_MHZ * TICK_US;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_CUR_LIM  = 8'h04;
  localparam logic [7:0]  OFS_CUR_TIME = 8'h08;
  localparam logic [7:0]  OFS_BLK_TIME = 8'h0C;
  localparam logic [7:0]  OFS_ACTIVE   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h18;
  // alert bit positions, shared by active, enable, shutdown, status, mask
  localparam int          N_ALERT      = 7;
  localparam int          A_CUR        = 0;
  localparam int          A_SIG        = 1;
  localparam int          A_PGM        = 2;
  localparam int          A_STAT       = 3;
  localparam int          A_CPU        = 4;
  localparam int          A_IOP        = 5;
  localparam int          A_BLK        = 6;
  // control layout: [6:0] enable, [14:8] shutdown, [16] zero power open
  localparam int          CTRL_SHD_LSB = 8;
  localparam int          CTRL_ZPO     = 16;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_003F;
  localparam logic [15:0] CUR_LIM_RST  = 16'h0064;
  localparam logic [15:0] CUR_TIME_RST = 16'h0005;
  localparam logic [15:0] BLK_TIME_RST = 16'h03E8;
endpackage

// ### valve_diag_alert_monitor.sv
// valve diagnostic alert monitor with apb registers and interrupt
`timescale 1ns/100ps
module valve_diag_alert_monitor #(
  parameter int TICK_CYCLES = alert_pkg::TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic [15:0] cur_expected,
  input  wire logic [15:0] cur_measured,
  input  wire logic [alert_pkg::PCT_W-1:0] drive_pct,
  input  wire logic [alert_pkg::PCT_W-1:0] travel_pct,
  input  wire logic        nonvolatile_memory_fail,
  input  wire logic        static_param_memory_fail,
  input  wire logic        cpu_fail,
  input  wire logic        iop_fail,
  input  wire logic        block_exec,
  output logic             out_of_service,
  output logic             zero_power,
  output logic             irq
);
  import alert_pkg::*;

  //==========================================================================
  // pin synchronisers
  //==========================================================================
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  wire  [4:0] pins = {block_exec, iop_fail, cpu_fail, static_param_memory_fail,
                      nonvolatile_memory_fail};
  // first stage read only by second stage
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end

  //==========================================================================
  // registers
  //==========================================================================
  logic [31:0]        ctrl_reg;
  logic [15:0]        cur_lim_reg;
  logic [15:0]        cur_time_reg;
  logic [15:0]        blk_time_reg;
  logic [N_ALERT-1:0] stat_reg;
  logic [N_ALERT-1:0] mask_reg;
  logic [N_ALERT-1:0] active;

  wire [N_ALERT-1:0] enable   = ctrl_reg[N_ALERT-1:0];
  wire [N_ALERT-1:0] shutdown = ctrl_reg[CTRL_SHD_LSB +: N_ALERT];
  wire               zp_open  = ctrl_reg[CTRL_ZPO];

  // apb decode; zero wait state, unmapped addresses answer with an error
  wire wr_en     = psel & penable & pwrite;
  wire hit_ctrl  = (paddr == OFS_CTRL);
  wire hit_lim   = (paddr == OFS_CUR_LIM);
  wire hit_time  = (paddr == OFS_CUR_TIME);
  wire hit_blk   = (paddr == OFS_BLK_TIME);
  wire hit_act   = (paddr == OFS_ACTIVE);
  wire hit_stat  = (paddr == OFS_IRQ_STAT);
  wire hit_mask  = (paddr == OFS_IRQ_MASK);
  wire mapped    = hit_ctrl | hit_lim | hit_time | hit_blk | hit_act | hit_stat | hit_mask;
  wire [31:0] rd_mux =
      hit_ctrl ? ctrl_reg :
      hit_lim  ? {16'h0000, cur_lim_reg} :
      hit_time ? {16'h0000, cur_time_reg} :
      hit_blk  ? {16'h0000, blk_time_reg} :
      hit_act  ? {25'h0000000, active} :
      hit_stat ? {25'h0000000, stat_reg} :
      hit_mask ? {25'h0000000, mask_reg} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // read data flopped during setup so it is steady in the access phase
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= rd_mux;

  // writable configuration
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_reg     <= CTRL_RESET;
      cur_lim_reg  <= CUR_LIM_RST;
      cur_time_reg <= CUR_TIME_RST;
      blk_time_reg <= BLK_TIME_RST;
      mask_reg     <= '0;
    end
    else if (wr_en)
    begin
      if (hit_ctrl) ctrl_reg     <= pwdata;
      if (hit_lim)  cur_lim_reg  <= pwdata[15:0];
      if (hit_time) cur_time_reg <= pwdata[15:0];
      if (hit_blk)  blk_time_reg <= pwdata[15:0];
      if (hit_mask) mask_reg     <= pwdata[N_ALERT-1:0];
    end

  //==========================================================================
  // millisecond tick divider
  //==========================================================================
  logic [31:0] div_reg;
  wire         tick = (div_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      div_reg <= 32'h0000_0000;
    else
      div_reg <= tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;

  //==========================================================================
  // drive current comparison
  //==========================================================================
  wire [15:0] cur_diff = (cur_expected > cur_measured) ? cur_expected - cur_measured
                                                       : cur_measured - cur_expected;
  wire        cur_bad  = (cur_diff > cur_lim_reg);
  logic [15:0] cur_cnt_reg;
  // counts milliseconds of continuous excess; any good sample restarts it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cur_cnt_reg <= 16'h0000;
    else if (!cur_bad)
      cur_cnt_reg <= 16'h0000;
    else if (tick && cur_cnt_reg != 16'hFFFF)
      cur_cnt_reg <= cur_cnt_reg + 16'h0001;
  wire cur_cond = cur_bad & (cur_cnt_reg > cur_time_reg);

  //==========================================================================
  // drive signal versus travel
  //==========================================================================
  wire drv_lo   = (drive_pct < DRIVE_LO);
  wire drv_hi   = (drive_pct > DRIVE_HI);
  wire trv_gt3  = (travel_pct > TRAVEL_LO);
  wire trv_lt97 = (travel_pct < TRAVEL_HI);
  wire sig_closed = (drv_lo & trv_gt3) | (drv_hi & trv_lt97);
  wire sig_open   = (drv_lo & trv_lt97) | (drv_hi & trv_gt3);
  wire sig_cond   = zp_open ? sig_open : sig_closed;

  //==========================================================================
  // output block execution watchdog
  //==========================================================================
  logic        exec_d_reg;
  logic [15:0] blk_cnt_reg;
  wire         exec_pulse = sync2_reg[4] & ~exec_d_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      exec_d_reg  <= 1'b0;
      blk_cnt_reg <= 16'h0000;
    end
    else
    begin
      exec_d_reg <= sync2_reg[4];
      if (exec_pulse)
        blk_cnt_reg <= 16'h0000;
      else if (tick && blk_cnt_reg != 16'hFFFF)
        blk_cnt_reg <= blk_cnt_reg + 16'h0001;
    end
  wire blk_cond = (blk_cnt_reg > blk_time_reg);

  //==========================================================================
  // alert vector, shutdown and interrupt
  //==========================================================================
  wire [N_ALERT-1:0] raw = {blk_cond, sync2_reg[3:0], sig_cond, cur_cond};
  // level alerts follow their condition; disabled ones stay low
  assign active = raw & enable;

  // drive signal alert is report only and cannot cause shutdown
  wire [N_ALERT-1:0] shd_eff = shutdown & ~(N_ALERT'(1) << A_SIG);

  // oos flopped so it follows the shutdown alerts one cycle later, set and release alike
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      out_of_service <= 1'b0;
    else
      out_of_service <= |(active & shd_eff);
  assign zero_power = out_of_service;

  // sticky status; a new rising alert wins over a write-one clear
  logic [N_ALERT-1:0] act_d_reg;
  wire  [N_ALERT-1:0] rise = active & ~act_d_reg;
  wire  [N_ALERT-1:0] clr  = (wr_en & hit_stat) ? pwdata[N_ALERT-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      act_d_reg <= '0;
      stat_reg  <= '0;
    end
    else
    begin
      act_d_reg <= active;
      stat_reg  <= (stat_reg & ~clr) | rise;
    end
  assign irq = |(stat_reg & mask_reg);

  //==========================================================================
  // assertions
  //==========================================================================
  property p_cur_alert;
    @(posedge pclk) disable iff (!presetn)
      (cur_bad && cur_cnt_reg > cur_time_reg && enable[A_CUR]) |-> active[A_CUR];
  endproperty
  a_cur_alert: assert property (p_cur_alert) else $error("current alert missing");

  property p_sig_closed;
    @(posedge pclk) disable iff (!presetn)
      (!zp_open && enable[A_SIG] &&
       ((drive_pct < DRIVE_LO && travel_pct > TRAVEL_LO) ||
        (drive_pct > DRIVE_HI && travel_pct < TRAVEL_HI)))
        |-> active[A_SIG];
  endproperty
  a_sig_closed: assert property (p_sig_closed) else $error("closed drive alert missing");

  property p_sig_open;
    @(posedge pclk) disable iff (!presetn)
      (zp_open && enable[A_SIG] &&
       ((drive_pct < DRIVE_LO && travel_pct < TRAVEL_HI) ||
        (drive_pct > DRIVE_HI && travel_pct > TRAVEL_LO)))
        |-> active[A_SIG];
  endproperty
  a_sig_open: assert property (p_sig_open) else $error("open drive alert missing");

  property p_sig_no_oos;
    @(posedge pclk) disable iff (!presetn)
      (active == (N_ALERT'(1) << A_SIG)) |=> !out_of_service;
  endproperty
  a_sig_no_oos: assert property (p_sig_no_oos) else $error("drive alert changed mode");

  property p_shutdown;
    @(posedge pclk) disable iff (!presetn)
      |(active & shd_eff) |=> out_of_service;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not taken");

  property p_zero_power;
    @(posedge pclk) disable iff (!presetn) out_of_service == zero_power;
  endproperty
  a_zero_power: assert property (p_zero_power) else $error("zero power mismatch");

  property p_cpu_alert;
    @(posedge pclk) disable iff (!presetn)
      $rose(sync2_reg[A_CPU - A_PGM]) && enable[A_CPU] |-> active[A_CPU];
  endproperty
  a_cpu_alert: assert property (p_cpu_alert) else $error("processor alert missing");

  property p_blk_timeout;
    @(posedge pclk) disable iff (!presetn)
      (blk_cnt_reg > blk_time_reg && enable[A_BLK]) |-> active[A_BLK];
  endproperty
  a_blk_timeout: assert property (p_blk_timeout) else $error("block timeout missing");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn) (active & ~enable) == '0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled alert active");

  property p_clear;
    @(posedge pclk) disable iff (!presetn) !out_of_service && (active & shd_eff) == '0
      ##1 (active & shd_eff) == '0 |=> !out_of_service;
  endproperty
  a_clear: assert property (p_clear) else $error("oos stuck");

  // shutdown releases one cycle after the last shutdown alert goes
  property p_oos_release;
    @(posedge pclk) disable iff (!presetn)
      (active & shd_eff) == '0 |=> !out_of_service;
  endproperty
  a_oos_release: assert property (p_oos_release) else $error("oos held without fault");

  // mid-band drive can never report a drive signal fault
  property p_sig_quiet;
    @(posedge pclk) disable iff (!presetn)
      (drive_pct >= DRIVE_LO && drive_pct <= DRIVE_HI) |-> !active[A_SIG];
  endproperty
  a_sig_quiet: assert property (p_sig_quiet) else $error("drive alert without cause");

  property p_stat_alert;
    @(posedge pclk) disable iff (!presetn)
      (sync2_reg[A_STAT - A_PGM] && enable[A_STAT]) |-> active[A_STAT];
  endproperty
  a_stat_alert: assert property (p_stat_alert) else $error("static alert missing");

  // an execution report always restarts the timeout, even on a tick
  property p_blk_restart;
    @(posedge pclk) disable iff (!presetn)
      exec_pulse |=> (blk_cnt_reg == '0);
  endproperty
  a_blk_restart: assert property (p_blk_restart) else $error("block timer kept");

  // status keeps every alert that rose, even against a same-cycle clear
  property p_status_set;
    @(posedge pclk) disable iff (!presetn)
      (rise != '0) |=> ((stat_reg & $past(rise)) == $past(rise));
  endproperty
  a_status_set: assert property (p_status_set) else $error("status lost a rising alert");

  c_oos:   cover property (@(posedge pclk) disable iff (!presetn) $rose(out_of_service));
  c_irq:   cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_blk:   cover property (@(posedge pclk) disable iff (!presetn) $rose(active[A_BLK]));
  c_sig:   cover property (@(posedge pclk) disable iff (!presetn) $rose(active[A_SIG]));
  c_cur:   cover property (@(posedge pclk) disable iff (!presetn) $rose(active[A_CUR]));
endmodule // valve_diag_alert_monitor

// ### testbench.sv
// self-checking testbench for the valve diagnostic alert monitor
`timescale 1ns/100ps
module testbench;
  import alert_pkg::*;
  //==========================================================================
  // stimulus signals and design under test
  logic        pclk, presetn, psel, penable, pwrite, block_exec;
  logic        pready, pslverr, oos, zp, irq, err_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed, r;
  logic [15:0] cur_e, cur_m;
  logic [9:0]  drv, trv, d, t;
  logic [3:0]  fails;
  int          mismatches, check_count;
  // boundary values around the drive and travel thresholds
  logic [9:0]  corner [12] = '{10'h063, 10'h064, 10'h065, 10'h383, 10'h384, 10'h385,
                               10'h01D, 10'h01E, 10'h01F, 10'h3C9, 10'h3CA, 10'h3CB};

  valve_diag_alert_monitor #(.TICK_CYCLES(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cur_expected(cur_e), .cur_measured(cur_m), .drive_pct(drv), .travel_pct(trv),
    .nonvolatile_memory_fail(fails[0]), .static_param_memory_fail(fails[1]),
    .cpu_fail(fails[2]), .iop_fail(fails[3]), .block_exec(block_exec),
    .out_of_service(oos), .zero_power(zp), .irq(irq)
  );

  // free-running 100 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  //==========================================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected drive signal alert for both zero-power senses
  function automatic logic sig_exp(logic zpo, logic [9:0] dv, logic [9:0] tv);
    logic lo, hi;
    lo = dv < DRIVE_LO;
    hi = dv > DRIVE_HI;
    return zpo ? (lo && tv < TRAVEL_HI) || (hi && tv > TRAVEL_LO)
               : (lo && tv > TRAVEL_LO) || (hi && tv < TRAVEL_HI);
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stalled access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(string nm, logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // short execution pulse of the output block
  task automatic pulse();
    @(posedge pclk);
    block_exec <= 1'b1;
    @(posedge pclk);
    block_exec <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end

  //==========================================================================
  // main sequence
  initial
  begin
    seed = 32'hC1101B48;
    {presetn, psel, penable, pwrite, block_exec} = 5'h00;
    {paddr, pwdata, cur_e, cur_m, drv, trv, fails} = '0;
    repeat (6) @(posedge pclk);
    chk("pready_reset", {31'h0, pready}, 32'h1);
    chk("irq_reset", {31'h0, irq}, 32'h0);
    chk("oos_reset", {31'h0, oos}, 32'h0);
    presetn <= 1'b1;
    rdchk("ctrl", OFS_CTRL, CTRL_RESET);
    rdchk("cur_lim", OFS_CUR_LIM, {16'h0, CUR_LIM_RST});
    rdchk("cur_time", OFS_CUR_TIME, {16'h0, CUR_TIME_RST});
    rdchk("blk_time", OFS_BLK_TIME, {16'h0, BLK_TIME_RST});
    rdchk("unmapped", 8'h1C, 32'h0);
    chk("pslverr", {31'h0, err_seen}, 32'h1);
    r = xs();
    apb(1'b1, OFS_CUR_LIM, r);
    rdchk("cur_lim_rw", OFS_CUR_LIM, {16'h0, r[15:0]});
    $display("done: registers");
    // random and boundary drive/travel pairs, shutdown asked even for drive signal
    for (int i = 0; i < 40; i++)
    begin
      r = xs();
      d = r[0] ? corner[r[7:4] % 12] : 10'(r[17:8] % 1001);
      t = r[1] ? corner[r[21:18] % 12] : 10'(r[31:22] % 1001);
      drv <= d;
      trv <= t;
      apb(1'b1, OFS_CTRL, {15'h0, i[0], 16'h7F3F});
      rdchk("drive_sig", OFS_ACTIVE, {30'h0, sig_exp(i[0], d, t), 1'b0});
      chk("oos_report_only", {31'h0, oos}, 32'h0);
    end
    $display("done: drive signal");
    // interrupt: sticky status, mask, write-one clear
    drv <= 10'h000;
    trv <= 10'h1F4;
    apb(1'b1, OFS_CTRL, 32'h3F);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    rdchk("status", OFS_IRQ_STAT, 32'h2);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    @(posedge pclk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    drv <= 10'h1F4;
    apb(1'b1, OFS_IRQ_STAT, 32'h7F);
    @(posedge pclk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rdchk("sig_cleared", OFS_ACTIVE, 32'h0);
    $display("done: interrupt");
    // each failure pin alone, with shutdown enabled, then all disabled
    apb(1'b1, OFS_CTRL, 32'h3C3F);
    for (int i = 0; i < 4; i++)
    begin
      fails <= 4'(1 << i);
      repeat (4) @(posedge pclk);
      rdchk("proc_active", OFS_ACTIVE, 32'(4 << i));
      chk("oos_proc", {31'h0, oos}, 32'h1);
      chk("zero_power", {31'h0, zp}, 32'h1);
      fails <= 4'h0;
      repeat (5) @(posedge pclk);
      chk("oos_recover", {31'h0, oos}, 32'h0);
    end
    apb(1'b1, OFS_CTRL, 32'h3C03);
    fails <= 4'hF;
    repeat (4) @(posedge pclk);
    rdchk("proc_disabled", OFS_ACTIVE, 32'h0);
    chk("oos_disabled", {31'h0, oos}, 32'h0);
    fails <= 4'h0;
    $display("done: processor");
    // current error one above the limit for 2 ms (4-cycle ticks)
    apb(1'b1, OFS_CUR_LIM, 32'hA);
    apb(1'b1, OFS_CUR_TIME, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h0101);
    cur_e <= 16'h0064;
    cur_m <= 16'h006F;
    repeat (4) @(posedge pclk);
    rdchk("cur_early", OFS_ACTIVE, 32'h0);
    repeat (20) @(posedge pclk);
    rdchk("cur_late", OFS_ACTIVE, 32'h1);
    chk("oos_cur", {31'h0, oos}, 32'h1);
    cur_m <= 16'h006E;
    repeat (3) @(posedge pclk);
    rdchk("cur_at_limit", OFS_ACTIVE, 32'h0);
    chk("oos_cur_off", {31'h0, oos}, 32'h0);
    $display("done: drive current");
    // output block timeout of 2 ms
    apb(1'b1, OFS_BLK_TIME, 32'h2);
    pulse();
    apb(1'b1, OFS_CTRL, 32'h4040);
    for (int i = 0; i < 6; i++)
    begin
      pulse();
      rdchk("blk_running", OFS_ACTIVE, 32'h0);
    end
    repeat (30) @(posedge pclk);
    rdchk("blk_timeout", OFS_ACTIVE, 32'h40);
    chk("oos_blk", {31'h0, oos}, 32'h1);
    pulse();
    repeat (5) @(posedge pclk);
    chk("oos_blk_off", {31'h0, oos}, 32'h0);
    $display("done: block timeout");
    give_verdict();
  end
endmodule // testbench
